// file: hdl/cve_pkg.sv
package cve_pkg;

    // ************************************************
    // Widths and map
    // ************************************************
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int MAX_VARS_DOC = 12;
    localparam logic [7:0] RD_BASE = 8'h00;
    localparam logic [7:0] WR_BASE = 8'h20;
    localparam logic [7:0] CTRL_ADDR = 8'h40;
    localparam logic [7:0] COUNT_ADDR = 8'h41;
    localparam logic [7:0] OPEN_ADDR = 8'h42;
    localparam logic [7:0] STAT_ADDR = 8'h43;
    localparam int OFS_MONITOR = 0;
    localparam int OFS_SECOND = 1;
    localparam int CTRL_RD_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ************************************************
    // Codes
    // ************************************************
    localparam logic [15:0] MON_TIMEOUT = 16'he999;
    localparam logic [7:0] SEND_FAIL_TAG = 8'hff;
    localparam logic [7:0] END_OK = 8'h00;
    localparam logic [7:0] END_NVM = 8'h21;
    localparam logic [7:0] END_NOEXEC = 8'h0d;
    localparam logic [7:0] END_RX_CHECK = 8'h97;
    localparam logic [15:0] RESP_NORMAL = 16'h0000;
    localparam logic [15:0] OP_DISABLED = 16'h0000;
    localparam logic [15:0] OP_ENABLED = 16'h0001;

    typedef enum logic [1:0] {K_READ = 2'h0, K_WRITE = 2'h1, K_OP = 2'h2} cve_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ISSUE = 3'h1,
        ST_WAIT = 3'h3,
        ST_FINISH = 3'h2,
        ST_REPORT = 3'h6
    } cve_state_t;

    // ************************************************
    // BCD item count
    // ************************************************
    function automatic logic [7:0] cve_bcd_bin(input logic [15:0] v);
        return 8'(8'(v[7:4]) * 8'h0a + 8'(v[3:0]));
    endfunction : cve_bcd_bin

    function automatic logic cve_bcd_ok(input logic [15:0] v, input int lim);
        return v[15:8] == 8'h00 && v[7:4] <= 4'h9 && v[3:0] <= 4'h9 && cve_bcd_bin(v) <= 8'(lim);
    endfunction : cve_bcd_ok

endpackage : cve_pkg

// file: hdl/cve_outcome_encoder.sv
`timescale 1ns/1ps
module cve_outcome_encoder (
    input wire logic is_write_in,    // Exchange is a write
    input wire logic timeout_in,     // Component gave no answer
    input wire logic [7:0] end_in,   // End code of the exchange
    input wire logic [15:0] resp_in, // Component response code
    output logic [15:0] word_out     // Response monitor word
);
    import cve_pkg::*;

    // ************************************************
    // Outcome priority: timeout, end code, response
    // ************************************************
    wire nvm_on_read = !is_write_in && end_in == END_NVM;
    wire [7:0] fault_code = nvm_on_read ? END_NOEXEC : end_in;
    wire [15:0] fault_word = {SEND_FAIL_TAG, fault_code};
    assign word_out = timeout_in ? MON_TIMEOUT :
                      (end_in != END_OK) ? fault_word :
                      resp_in;

endmodule : cve_outcome_encoder

// file: hdl/cve_exchange.sv
`timescale 1ns/1ps
module cve_exchange #(
    parameter int MAX_VARS = 12,                        // Variables per exchange
    parameter logic [15:0] AUTOTUNE_OP_CODE = 16'h0a00  // Auto-tune start word, arbitrary value
) (
    input wire logic clk_sys_in,                          // System clock
    input wire logic rst_n_in,                            // Async reset, active low
    input wire logic [cve_pkg::ADDR_W-1:0] reg_addr_in,   // Register word address
    input wire logic [cve_pkg::DATA_W-1:0] reg_wdata_in,  // Register write data
    input wire logic reg_wr_in,                           // Write strobe
    input wire logic reg_rd_in,                           // Read strobe
    output logic [cve_pkg::DATA_W-1:0] reg_rdata_out,     // Read data, next cycle
    output logic link_req_out,                            // One-cycle request to link
    output cve_pkg::cve_kind_t link_kind_out,             // Request kind
    output logic [3:0] link_index_out,                    // Variable number
    output logic [31:0] link_data_out,                    // Setpoint or operation word
    input wire logic link_done_in,                        // Answer pulse
    input wire logic link_timeout_in,                     // No answer from component
    input wire logic [7:0] link_end_in,                   // End code
    input wire logic [15:0] link_resp_in,                 // Component response code
    input wire logic [31:0] link_rdata_in,                // Variable value read
    input wire logic [15:0] link_state_in,                // Component status word
    output logic busy_out,                                // Exchange running
    output logic done_out                                 // Completion pulse
);
    import cve_pkg::*;

    localparam int NW = 2 + 2 * MAX_VARS;

    generate
        if (MAX_VARS < 1 || MAX_VARS > MAX_VARS_DOC) begin : g_bad_vars
            $error("MAX_VARS must be 1 to 12");
        end
    endgenerate

    // ************************************************
    // State
    // ************************************************
    cve_state_t state_reg, state_next;
    logic [15:0] rd_area_reg [NW];
    logic [15:0] rd_area_next [NW];
    logic [15:0] wr_area_reg [NW];
    logic [15:0] wr_area_next [NW];
    logic [15:0] count_reg, op_en_reg;
    logic trig_reg, syntax_reg, is_write_reg, skip_sp_reg, op_sent_reg;
    logic [3:0] total_reg, idx_reg;
    logic out_timeout_reg;
    logic [7:0] out_end_reg;
    logic [15:0] out_resp_reg;
    logic link_req_reg;
    cve_kind_t link_kind_reg;
    logic [3:0] link_index_reg;
    logic [31:0] link_data_reg;
    logic [15:0] rdata_reg;
    logic done_reg, busy_reg;

    // ************************************************
    // Decode
    // ************************************************
    wire ctrl_wr = reg_wr_in && reg_addr_in == CTRL_ADDR;
    wire start_rd = ctrl_wr && reg_wdata_in[CTRL_RD_BIT];
    wire set_trig = ctrl_wr && reg_wdata_in[CTRL_WR_BIT];
    wire [7:0] wr_ofs = reg_addr_in - WR_BASE;
    wire rd_hit = reg_addr_in - RD_BASE < 8'(NW);
    wire wr_hit = reg_addr_in >= WR_BASE && wr_ofs < 8'(NW);
    wire sw_area_wr = reg_wr_in && wr_hit && wr_ofs != 8'(OFS_MONITOR);
    wire count_ok = cve_bcd_ok(count_reg, MAX_VARS);
    wire op_ok = op_en_reg == OP_DISABLED || op_en_reg == OP_ENABLED;
    wire launch = state_reg == ST_IDLE && (start_rd || trig_reg);
    wire launch_wr = !start_rd;
    wire launch_bad = launch && !(count_ok && (op_ok || !launch_wr));
    wire launch_go = launch && !launch_bad;
    wire autotune = op_en_reg == OP_ENABLED && wr_area_reg[OFS_SECOND] == AUTOTUNE_OP_CODE;
    wire var_left = !skip_sp_reg && idx_reg < total_reg;
    wire op_wanted = is_write_reg && op_en_reg == OP_ENABLED && !op_sent_reg;
    wire [3:0] var_num = idx_reg + 4'h1;
    wire [4:0] lo_idx = {var_num, 1'b0};
    wire [4:0] hi_idx = 5'(lo_idx + 5'h01);
    wire issue_var = state_reg == ST_ISSUE && var_left;
    wire issue_op = state_reg == ST_ISSUE && !var_left && op_wanted;
    wire ans_in = state_reg == ST_WAIT && link_done_in;
    wire ans_ok = !link_timeout_in && link_end_in == END_OK && link_resp_in == RESP_NORMAL;
    wire var_ok = ans_in && ans_ok && link_kind_reg != K_OP;
    wire read_fail = ans_in && !ans_ok && !is_write_reg;
    wire wr_fail = ans_in && !ans_ok && is_write_reg;
    wire clear_trig = (state_reg == ST_REPORT && is_write_reg) || (launch_bad && launch_wr);
    wire [15:0] monitor_word;
    wire [15:0] stat_word = {13'h0000, syntax_reg, trig_reg, busy_reg};
    wire [15:0] rdata_sel = rd_hit ? rd_area_reg[reg_addr_in[4:0]] :
                            wr_hit ? wr_area_reg[wr_ofs[4:0]] :
                            reg_addr_in == COUNT_ADDR ? count_reg :
                            reg_addr_in == OPEN_ADDR ? op_en_reg :
                            reg_addr_in == STAT_ADDR ? stat_word : 16'h0000;
    wire [31:0] sp_word = {wr_area_reg[hi_idx], wr_area_reg[lo_idx]};
    wire [31:0] op_word = {16'h0000, wr_area_reg[OFS_SECOND]};

    cve_outcome_encoder u_encoder (
        .is_write_in(is_write_reg),
        .timeout_in(out_timeout_reg),
        .end_in(out_end_reg),
        .resp_in(out_resp_reg),
        .word_out(monitor_word)
    );

    // ************************************************
    // Sequencer
    // ************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: if (launch_go) state_next = ST_ISSUE;
            ST_ISSUE: state_next = (var_left || op_wanted) ? ST_WAIT : ST_FINISH;
            ST_WAIT: begin
                if (link_done_in) begin
                    state_next = (ans_ok && link_kind_reg != K_OP) ? ST_ISSUE : ST_FINISH;
                end
            end
            ST_FINISH: state_next = ST_REPORT;
            ST_REPORT: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_IDLE;
            is_write_reg <= 1'b0;
            skip_sp_reg <= 1'b0;
            op_sent_reg <= 1'b0;
            total_reg <= 4'h0;
            idx_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            if (launch_go) begin
                is_write_reg <= launch_wr;
                skip_sp_reg <= launch_wr && autotune;
                op_sent_reg <= 1'b0;
                total_reg <= 4'(cve_bcd_bin(count_reg));
                idx_reg <= 4'h0;
            end
            if (issue_op) op_sent_reg <= 1'b1;
            if (var_ok) idx_reg <= var_num;
        end
    end

    // Outcome of the latest answer decides the monitor word
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_timeout_reg <= 1'b0;
            out_end_reg <= END_OK;
            out_resp_reg <= RESP_NORMAL;
        end else if (launch_go) begin
            out_timeout_reg <= 1'b0;
            out_end_reg <= END_OK;
            out_resp_reg <= RESP_NORMAL;
        end else if (ans_in) begin
            out_timeout_reg <= link_timeout_in;
            out_end_reg <= link_end_in;
            out_resp_reg <= link_resp_in;
        end
    end

    // ************************************************
    // Link requests
    // ************************************************
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_req_reg <= 1'b0;
            link_kind_reg <= K_READ;
            link_index_reg <= 4'h0;
            link_data_reg <= 32'h0000_0000;
        end else begin
            link_req_reg <= issue_var || issue_op;
            if (issue_var || issue_op) begin
                link_kind_reg <= issue_op ? K_OP : (is_write_reg ? K_WRITE : K_READ);
                link_index_reg <= issue_op ? 4'h0 : var_num;
                link_data_reg <= issue_op ? op_word : (is_write_reg ? sp_word : 32'h0000_0000);
            end
        end
    end

    // ************************************************
    // Result and setpoint areas
    // ************************************************
    always_comb begin
        for (int k = 0; k < NW; k++) begin
            rd_area_next[k] = rd_area_reg[k];
            wr_area_next[k] = wr_area_reg[k];
        end
        if (sw_area_wr) wr_area_next[wr_ofs[4:0]] = reg_wdata_in;
        if (ans_in && !is_write_reg && !link_timeout_in) rd_area_next[OFS_SECOND] = link_state_in;
        if (var_ok && !is_write_reg) begin
            rd_area_next[lo_idx] = link_rdata_in[15:0];
            rd_area_next[hi_idx] = link_rdata_in[31:16];
        end
        if (read_fail) begin
            for (int k = 2; k < NW; k++) begin
                if (k >= int'(lo_idx)) rd_area_next[k] = RESET_WORD;
            end
        end
        if (state_reg == ST_FINISH) begin
            if (is_write_reg) wr_area_next[OFS_MONITOR] = monitor_word;
            else rd_area_next[OFS_MONITOR] = monitor_word;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int k = 0; k < NW; k++) begin
                rd_area_reg[k] <= RESET_WORD;
                wr_area_reg[k] <= RESET_WORD;
            end
        end else begin
            rd_area_reg <= rd_area_next;
            wr_area_reg <= wr_area_next;
        end
    end

    // ************************************************
    // Control registers and read port
    // ************************************************
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= RESET_WORD;
            op_en_reg <= RESET_WORD;
            trig_reg <= 1'b0;
            syntax_reg <= 1'b0;
            rdata_reg <= RESET_WORD;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            if (reg_wr_in && reg_addr_in == COUNT_ADDR) count_reg <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == OPEN_ADDR) op_en_reg <= reg_wdata_in;
            // Set wins over the hardware clear
            trig_reg <= set_trig || (trig_reg && !clear_trig);
            if (launch_bad) syntax_reg <= 1'b1;
            else if (launch_go) syntax_reg <= 1'b0;
            rdata_reg <= reg_rd_in ? rdata_sel : RESET_WORD;
            done_reg <= state_reg == ST_REPORT;
            busy_reg <= state_next != ST_IDLE;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign link_req_out = link_req_reg;
    assign link_kind_out = link_kind_reg;
    assign link_index_out = link_index_reg;
    assign link_data_out = link_data_reg;
    assign busy_out = busy_reg;
    assign done_out = done_reg;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    wire fin_fault = state_reg == ST_FINISH && !out_timeout_reg && out_end_reg != END_OK;

    a_end_code_kept: assert property (fin_fault && is_write_reg && out_end_reg != END_NVM
        |=> wr_area_reg[OFS_MONITOR][7:0] == $past(out_end_reg)) else $error("end code lost");
    a_fail_tag_ff: assert property (fin_fault && !is_write_reg
        |=> rd_area_reg[OFS_MONITOR][15:8] == SEND_FAIL_TAG) else $error("send fail tag missing");
    a_fault_code_map: assert property (fin_fault && !is_write_reg && out_end_reg != END_NVM
        |=> rd_area_reg[OFS_MONITOR] == {SEND_FAIL_TAG, $past(out_end_reg)}) else $error("fault code wrong");
    a_rx_check_code: assert property (fin_fault && out_end_reg == END_RX_CHECK
        |=> rd_area_reg[OFS_MONITOR][7:0] == END_RX_CHECK || wr_area_reg[OFS_MONITOR][7:0] == END_RX_CHECK)
        else $error("check mismatch code wrong");
    a_nvm_write_only: assert property (fin_fault && out_end_reg == END_NVM
        |=> $past(is_write_reg) ? wr_area_reg[OFS_MONITOR] == {SEND_FAIL_TAG, END_NVM}
                                : rd_area_reg[OFS_MONITOR] == {SEND_FAIL_TAG, END_NOEXEC})
        else $error("memory write code misplaced");
    a_timeout_code: assert property (state_reg == ST_FINISH && out_timeout_reg && !is_write_reg
        |=> rd_area_reg[OFS_MONITOR] == MON_TIMEOUT) else $error("timeout code missing");
    a_resp_code_kept: assert property (state_reg == ST_FINISH && !out_timeout_reg && out_end_reg == END_OK
        && is_write_reg |=> wr_area_reg[OFS_MONITOR] == $past(out_resp_reg)) else $error("response code lost");
    a_status_word: assert property (ans_in && !is_write_reg && !link_timeout_in
        |=> rd_area_reg[OFS_SECOND] == $past(link_state_in)) else $error("status word not stored");
    a_var_split: assert property (var_ok && !is_write_reg
        |=> {rd_area_reg[$past(hi_idx)], rd_area_reg[$past(lo_idx)]} == $past(link_rdata_in))
        else $error("variable halves misplaced");
    a_tail_zeroed: assert property (read_fail
        |=> rd_area_reg[NW-1] == RESET_WORD && rd_area_reg[$past(lo_idx)] == RESET_WORD)
        else $error("tail not cleared");
    a_autotune_skip: assert property (link_req_reg && link_kind_reg == K_WRITE |-> !skip_sp_reg)
        else $error("setpoint sent during auto-tune");
    sequence s_wr_fail_quiet;
        wr_fail ##1 !set_trig [*2];
    endsequence
    a_trig_cleared: assert property (s_wr_fail_quiet |=> !trig_reg)
        else $error("write trigger not cleared");
    a_abort_stops: assert property (wr_fail |=> !link_req_reg [*3])
        else $error("request after write error");
    a_op_enable: assert property (link_req_reg && link_kind_reg == K_OP |-> $past(op_en_reg) == OP_ENABLED)
        else $error("operation word sent while disabled");
    sequence s_finish_report;
        state_reg == ST_FINISH ##1 state_reg == ST_REPORT;
    endsequence
    a_done_after_mon: assert property (s_finish_report |=> done_reg ##1 !done_reg)
        else $error("completion pulse wrong");
    a_done_cause: assert property (done_reg |-> $past(state_reg, 2) == ST_FINISH)
        else $error("completion without monitor update");

endmodule : cve_exchange

// file: tb/cve_link_model.sv
`timescale 1ns/1ps
module cve_link_model (
    input wire logic clk_sys_in,          // System clock
    input wire logic rst_n_in,            // Async reset, active low
    input wire logic req_in,              // Request pulse
    input wire logic [3:0] index_in,      // Variable number
    input wire logic [3:0] fail_idx_in,   // Variable that fails
    input wire logic [1:0] fail_kind_in,  // 1 silence, 2 end code, 3 response code
    input wire logic [15:0] fail_code_in, // Fault code
    input wire logic [3:0] delay_in,      // Answer delay in cycles
    output logic done_out,                // Answer pulse
    output logic timeout_out,             // No answer
    output logic [7:0] end_out,           // End code
    output logic [15:0] resp_out,         // Response code
    output logic [31:0] rdata_out,        // Variable value
    output logic [15:0] state_out         // Component status
);
    logic pend_reg;
    logic [3:0] wait_reg;
    logic [3:0] idx_reg;
    wire hit = idx_reg == fail_idx_in;
    wire [31:0] pat = {12'ha5c, idx_reg, 12'h3c0, idx_reg};
    // Lines carry inverted values outside the answer cycle
    assign timeout_out = done_out ? (hit && fail_kind_in == 2'h1) : 1'b1;
    assign end_out = (done_out == (hit && fail_kind_in == 2'h2)) ? fail_code_in[7:0] : 8'h00;
    assign resp_out = (done_out == (hit && fail_kind_in == 2'h3)) ? fail_code_in : 16'h0000;
    assign rdata_out = done_out ? pat : ~pat;
    assign state_out = done_out ? {12'h5a0, idx_reg} : {12'ha5f, ~idx_reg};
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_reg <= 1'b0;
            wait_reg <= 4'h0;
            idx_reg <= 4'h0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (req_in) begin
                pend_reg <= 1'b1;
                wait_reg <= delay_in;
                idx_reg <= index_in;
            end else if (pend_reg && wait_reg > 4'h1) begin
                wait_reg <= wait_reg - 4'h1;
            end else if (pend_reg) begin
                pend_reg <= 1'b0;
                done_out <= 1'b1;
            end
        end
    end
endmodule : cve_link_model

// file: tb/cve_exchange_tb.sv
`timescale 1ns/1ps
module cve_exchange_tb;
    import cve_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [15:0] reg_rdata_out, link_resp_in, link_state_in, op;
    logic link_req_out, link_done_in, link_timeout_in, busy_out, done_out;
    cve_kind_t link_kind_out;
    logic [3:0] link_index_out;
    logic [31:0] link_data_out, link_rdata_in, sp;
    logic [7:0] link_end_in;
    logic [3:0] fail_idx = 4'hf;
    logic [1:0] fail_kind = 2'h0;
    logic [15:0] fail_code = 16'h0000;
    logic [3:0] delay = 4'h1;
    int err_count = 0;
    int cmp_count = 0;
    logic rd_seen = 1'b0;
    logic [15:0] rd_q[$];
    logic [37:0] lk_q[$];
    logic [7:0] codes[11] = '{8'h04, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h97};
    logic [7:0] idle_addr[7] = '{RD_BASE, 8'(RD_BASE + 8'h02), 8'(WR_BASE + 8'h01), COUNT_ADDR, OPEN_ADDR, CTRL_ADDR,
                                 8'h80};
    cve_exchange #(.MAX_VARS(12), .AUTOTUNE_OP_CODE(16'h0a00)) i_cve_exchange (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .link_req_out(link_req_out),
        .link_kind_out(link_kind_out), .link_index_out(link_index_out), .link_data_out(link_data_out),
        .link_done_in(link_done_in), .link_timeout_in(link_timeout_in), .link_end_in(link_end_in),
        .link_resp_in(link_resp_in), .link_rdata_in(link_rdata_in), .link_state_in(link_state_in),
        .busy_out(busy_out), .done_out(done_out));
    cve_link_model i_cve_link_model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(link_req_out),
        .index_in(link_index_out), .fail_idx_in(fail_idx), .fail_kind_in(fail_kind), .fail_code_in(fail_code),
        .delay_in(delay), .done_out(link_done_in), .timeout_out(link_timeout_in), .end_out(link_end_in),
        .resp_out(link_resp_in), .rdata_out(link_rdata_in), .state_out(link_state_in));
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // ************************************************
    // Checking
    // ************************************************
    task automatic chk(input string what, input logic [37:0] exp, input logic [37:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    always @(posedge clk_sys_in) begin
        if (rd_seen) chk("read data", rd_q.size() ? 38'(rd_q.pop_front()) : 'x, 38'(reg_rdata_out));
        rd_seen <= reg_rd_in;
        if (link_req_out) chk("link request", lk_q.size() ? lk_q.pop_front() : 'x,
            {link_kind_out, link_index_out, link_data_out});
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    // ************************************************
    // Register bus and exchanges
    // ************************************************
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
    endtask : rd
    task automatic go(input logic [15:0] ctrl);
        int n;
        logic bsy;
        wr(CTRL_ADDR, ctrl);
        n = 0;
        bsy = 1'b0;
        while (done_out !== 1'b1 && n < 400) begin
            @(posedge clk_sys_in);
            bsy = bsy | busy_out;
            n++;
        end
        chk("exchange end", 38'h0, 38'(n == 400 || lk_q.size() != 0));
        chk("busy span", 38'h2, 38'({bsy, busy_out}));
    endtask : go
    task automatic set_fault(input logic [3:0] fi, input logic [1:0] fk, input logic [15:0] fc);
        fail_idx <= fi;
        fail_kind <= fk;
        fail_code <= fc;
        delay <= 4'($urandom_range(1, 7));
    endtask : set_fault
    task automatic rd_run(input logic [3:0] cnt, input logic [3:0] fi, input logic [1:0] fk, input logic [15:0] fc,
                          input logic [15:0] mon);
        set_fault(fi, fk, fc);
        wr(COUNT_ADDR, {12'h000, cnt});
        for (int i = 1; i <= cnt && i <= fi; i++) lk_q.push_back({K_READ, 4'(i), 32'h0});
        go(16'h0001);
        rd(RD_BASE, mon);
        for (int i = 1; i <= cnt; i++) begin
            rd(8'(RD_BASE + 2 * i), i < fi ? {12'h3c0, 4'(i)} : 16'h0000);
            rd(8'(RD_BASE + 2 * i + 1), i < fi ? {12'ha5c, 4'(i)} : 16'h0000);
        end
    endtask : rd_run
    task automatic wr_run(input logic [3:0] cnt, input logic [15:0] en, input logic [15:0] opw, input logic [3:0] fi,
                          input logic [15:0] fc, input logic [15:0] mon);
        set_fault(fi, fc == 16'h0 ? 2'h0 : 2'h2, fc);
        wr(COUNT_ADDR, {12'h000, cnt});
        wr(OPEN_ADDR, en);
        wr(8'(WR_BASE + 1), opw);
        for (int i = 1; i <= cnt; i++) begin
            sp = $urandom;
            wr(8'(WR_BASE + 2 * i), sp[15:0]);
            wr(8'(WR_BASE + 2 * i + 1), sp[31:16]);
            if (i <= fi && !(en == OP_ENABLED && opw == 16'h0a00)) lk_q.push_back({K_WRITE, 4'(i), sp});
        end
        if (en == OP_ENABLED && fi > cnt) lk_q.push_back({K_OP, 4'h0, 16'h0000, opw});
        go(16'h0002);
        rd(WR_BASE, mon);
        rd(STAT_ADDR, 16'h0000);
    endtask : wr_run
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        err_count++;
        summarize();
    end
    initial begin
        void'($urandom(67));
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        wr(8'(RD_BASE + 2), 16'hbeef);
        foreach (idle_addr[k]) begin
            rd(idle_addr[k], RESET_WORD);
        end
        rd_run(4'h3, 4'hf, 2'h0, 16'h0, RESP_NORMAL);
        rd(RD_BASE + 8'h01, 16'h5a03);
        foreach (codes[k]) begin
            rd_run(4'h3, 4'h2, 2'h2, {8'h00, codes[k]}, {SEND_FAIL_TAG, codes[k]});
            rd_run(4'h3, 4'hf, 2'h0, 16'h0, RESP_NORMAL);
        end
        rd_run(4'h3, 4'h1, 2'h1, 16'h0, MON_TIMEOUT);
        rd_run(4'h2, 4'h2, 2'h3, 16'h1003, 16'h1003);
        wr(OPEN_ADDR, 16'h0002);
        wr(CTRL_ADDR, 16'h0002);
        rd(STAT_ADDR, 16'h0004);
        op = {8'h05, 8'($urandom)};
        wr_run(4'h2, OP_ENABLED, op, 4'hf, 16'h0, RESP_NORMAL);
        wr_run(4'h3, OP_ENABLED, op, 4'h2, 16'h0021, 16'hff21);
        wr_run(4'h2, OP_ENABLED, 16'h0a00, 4'hf, 16'h0, RESP_NORMAL);
        wr_run(4'h0, OP_DISABLED, op, 4'hf, 16'h0, RESP_NORMAL);
        wr(COUNT_ADDR, 16'h0013);
        wr(CTRL_ADDR, 16'h0001);
        repeat (6) @(posedge clk_sys_in);
        rd(STAT_ADDR, 16'h0004);
        repeat (3) @(posedge clk_sys_in);
        summarize();
    end
endmodule : cve_exchange_tb
